// ### core/dimr_top.sv
// Digital input merge and run command logic with APB register access
`include "dimr_defines.svh"
module dimr_top
	import dimr_pkg::*;
#(
	parameter int TICK_CYC = `DIMR_TICK_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  local_pins,
	input  wire logic        enable_b_pin,
	input  wire logic [9:0]  serial_board,
	input  wire logic [9:0]  fieldbus_board,
	input  wire logic [7:0]  auxiliary_inputs,
	input  wire logic [3:0]  virtual_aux_outputs,
	input  wire logic [3:0]  timed_flags,
	input  wire logic        keypad_start_key,
	input  wire logic        keypad_stop_key,
	input  wire logic        main_ref_nonzero,
	input  wire logic        ramp_at_zero,
	output logic             run,
	output logic             run_reverse,
	output logic             decel_active,
	output logic             ref_force_zero,
	output logic             drive_enable,
	output logic             alarm_reset,
	output logic             encoder_channel_a,
	output logic             encoder_channel_b,
	output logic             frequency_input_a,
	output logic             frequency_input_b
);
	dimr_board_if bif ();

	// Selects input n (1..8) of a board, zero means unassigned
	function automatic logic board_pick(input logic [3:0] sel, input logic [7:0] brd);
		return (sel != 4'h0 && sel <= 4'h8) ? brd[3'(sel - 4'h1)] : 1'b0;
	endfunction

	// Configuration registers
	logic [31:0] ctrl_q;
	logic [4:0]  start_sel_q;
	logic [31:0] timer_q [10];
	logic [31:0] prdata_q;
	logic        pslverr_q;

	// Registered terminal inputs
	logic [8:0] pin_sync;
	logic [9:0] serial_q;
	logic [9:0] fieldbus_q;
	logic [7:0] aux_q;
	logic [3:0] vaux_q;
	logic [3:0] tflag_q;
	logic       kp_start_q;
	logic       kp_stop_q;

	logic [7:0] local_board;
	logic       local_paired_enable;

	// Field contacts cross in through two flops
	dimr_pin_sync #(
		.W (9)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.pin_in   ({enable_b_pin, local_pins}),
		.pin_sync (pin_sync)
	);

	// Link boards come from same-clock logic, one register stage only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{serial_q, fieldbus_q, aux_q, vaux_q, tflag_q, kp_start_q, kp_stop_q} <= '0;
		end else begin
			{serial_q, fieldbus_q, aux_q, vaux_q, tflag_q, kp_start_q, kp_stop_q} <=
				{serial_board, fieldbus_board, auxiliary_inputs, virtual_aux_outputs, timed_flags,
				keypad_start_key, keypad_stop_key}; // RULE22
		end
	end

	assign local_board         = pin_sync[7:0];
	// Channel A is the input two contact; a single open contact disables
	assign local_paired_enable = pin_sync[1] & pin_sync[8]; // RULE3

	// Alternate uses of inputs six to eight, alongside command use
	assign encoder_channel_a = local_board[5]; // RULE9
	assign frequency_input_a = local_board[5];
	assign encoder_channel_b = local_board[6];
	assign frequency_input_b = local_board[7];

	// Board merge
	logic       ser_act;
	logic       fb_act;
	logic [3:0] swen_sel;
	logic [7:0] comb_inputs;
	logic       comb_enable;
	logic       comb_swen;

	assign ser_act  = ctrl_q[`DIMR_CTRL_SER_ACT];
	assign fb_act   = ctrl_q[`DIMR_CTRL_FB_ACT];
	assign swen_sel = ctrl_q[`DIMR_CTRL_SWEN_LSB +: 4];

	always_comb begin
		comb_inputs = local_board
			| (ser_act ? serial_q[7:0] : 8'h00)
			| (fb_act ? fieldbus_q[7:0] : 8'h00); // RULE1
		comb_enable = local_paired_enable;
		if (!ctrl_q[`DIMR_CTRL_BYPASS]) begin
			comb_enable = comb_enable
				& (!ser_act | serial_q[`DIMR_BIT_ENABLE])
				& (!fb_act | fieldbus_q[`DIMR_BIT_ENABLE]); // RULE2
		end
		// Unassigned software enable reads active
		comb_swen = 1'b1;
		if (swen_sel != 4'h0) begin
			comb_swen = board_pick(swen_sel, local_board)
				& (!ser_act | board_pick(swen_sel, serial_q[7:0]))
				& (!fb_act | board_pick(swen_sel, fieldbus_q[7:0])); // RULE4
		end
	end

	assign bif.combined = {comb_swen, comb_enable, comb_inputs}; // RULE5

	// Timer tick divider; one-cycle enable pulse
	logic [$clog2(TICK_CYC)-1:0] div_q;
	logic                        tick_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (div_q == ($clog2(TICK_CYC))'(TICK_CYC - 1)) begin
			div_q  <= '0;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	assign bif.tick      = tick_q;
	assign bif.timer_cfg = timer_q;

	dimr_board_delay #(
		.CW (16)
	) u_delay (
		.pclk    (pclk),
		.presetn (presetn),
		.bd      (bif.delay)
	);

	// Terminal commands are read from the delayed board; aux, virtual, flag and keypad sources bypass it
	logic [7:0] dly_in;
	logic       dly_enable;
	logic       dly_swen;

	assign dly_in     = bif.delayed[7:0]; // RULE6
	assign dly_enable = bif.delayed[`DIMR_BIT_ENABLE];
	assign dly_swen   = bif.delayed[`DIMR_BIT_SWEN];

	// Fixed functions: enable on input two, reset on input three
	assign drive_enable = dly_enable & dly_swen; // RULE8
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_reset <= 1'b0;
		end else begin
			alarm_reset <= dly_in[2] & ~ctrl_q[`DIMR_CTRL_RST_DIS]; // RULE8
		end
	end

	// Start source: 0..7 inputs, 8..15 aux, 16..19 virtual, 20..23 flags
	logic start_cmd;
	always_comb begin
		start_cmd = 1'b0;
		if (start_sel_q < 5'd8) begin
			start_cmd = dly_in[start_sel_q[2:0]]; // RULE10
		end else if (start_sel_q < 5'd16) begin
			start_cmd = aux_q[start_sel_q[2:0]];
		end else if (start_sel_q < 5'd20) begin
			start_cmd = vaux_q[start_sel_q[1:0]];
		end else if (start_sel_q < 5'd24) begin
			start_cmd = tflag_q[start_sel_q[1:0]];
		end
	end

	// Function assignments
	logic [3:0] rev_sel;
	logic [3:0] jog_sel;
	logic [3:0] stop_sel;
	logic       rev_cmd;
	logic       jog_cmd;
	logic       stop_cmd;

	assign rev_sel  = ctrl_q[`DIMR_CTRL_REV_LSB +: 4];
	assign jog_sel  = ctrl_q[`DIMR_CTRL_JOG_LSB +: 4];
	assign stop_sel = ctrl_q[`DIMR_CTRL_STOP_LSB +: 4];
	assign rev_cmd  = board_pick(rev_sel, dly_in);
	assign jog_cmd  = board_pick(jog_sel, dly_in);
	assign stop_cmd = board_pick(stop_sel, dly_in);

	// Pulse style latches for stop-function and keypad operation
	logic start_prev_q;
	logic pulse_run_q;
	logic key_run_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_prev_q <= 1'b0;
			pulse_run_q  <= 1'b0;
		end else begin
			start_prev_q <= start_cmd;
			// Stop contact is normally closed; opening it wins over start
			if (!stop_cmd) begin
				pulse_run_q <= 1'b0; // RULE18
			end else if (start_cmd && !start_prev_q) begin
				pulse_run_q <= 1'b1; // RULE18
			end
		end
	end

	// Stop key wins when both keys are pressed together
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_run_q <= 1'b0;
		end else if (kp_stop_q) begin
			key_run_q <= 1'b0; // RULE19
		end else if (kp_start_q) begin
			key_run_q <= 1'b1; // RULE19
		end
	end

	// Run request and direction
	logic other_req;
	logic req_dir_rev;
	logic run_req;
	logic run_d;

	always_comb begin
		req_dir_rev = 1'b0;
		if (ctrl_q[`DIMR_CTRL_KEYPAD]) begin
			other_req = key_run_q; // RULE19
		end else if (stop_sel != 4'h0) begin
			other_req = pulse_run_q; // RULE18
		end else if (rev_sel != 4'h0) begin
			// Both active cannot be read as a direction
			other_req   = start_cmd ^ rev_cmd; // RULE15
			req_dir_rev = rev_cmd & ~start_cmd; // RULE16
		end else begin
			other_req = start_cmd; // RULE11
		end
		run_req = other_req;
		if (jog_sel != 4'h0 && !other_req) begin
			run_req = jog_cmd; // RULE17
		end
		run_d = run_req & drive_enable // RULE12
			& (!ctrl_q[`DIMR_CTRL_SCALAR] | main_ref_nonzero); // RULE14
	end

	// Run state machine
	dimr_run_e state_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q     <= DIMR_STANDBY;
			run_reverse <= 1'b0;
		end else begin
			case (state_q)
				DIMR_STANDBY: begin
					if (run_d) begin
						state_q     <= DIMR_RUNNING; // RULE12
						run_reverse <= req_dir_rev;
					end
				end
				DIMR_RUNNING: begin
					if (!run_d) begin
						// Free wheel drops straight to standby, no ramp
						state_q <= ctrl_q[`DIMR_CTRL_FREEWHEEL]
							? DIMR_STANDBY : DIMR_DECEL; // RULE20 RULE13
					end else begin
						run_reverse <= req_dir_rev;
					end
				end
				DIMR_DECEL: begin
					if (run_d) begin
						state_q     <= DIMR_RUNNING;
						run_reverse <= req_dir_rev;
					end else if (ramp_at_zero || !drive_enable) begin
						state_q <= DIMR_STANDBY; // RULE13
					end
				end
				default: begin
					state_q <= DIMR_STANDBY;
				end
			endcase
		end
	end

	assign run            = (state_q == DIMR_RUNNING);
	assign decel_active   = (state_q == DIMR_DECEL);
	assign ref_force_zero = !run; // RULE13

	// APB slave: zero wait states, read data captured in setup phase
	logic setup;
	logic wr_access;
	logic mapped;
	logic is_timer;
	logic [3:0] tidx;

	assign setup     = psel & ~penable;
	assign wr_access = psel & penable & pwrite;
	assign is_timer  = paddr >= `DIMR_OFF_TIMER0 && paddr <= `DIMR_OFF_TIMER9 && paddr[1:0] == 2'b00;
	assign tidx      = 4'(paddr[5:2] - 4'h0);
	assign mapped    = is_timer || (paddr[1:0] == 2'b00 && paddr <= `DIMR_OFF_RUN
		&& paddr != 12'h008 && paddr != 12'h00C);
	assign pready    = 1'b1;
	assign prdata    = prdata_q;
	assign pslverr   = pslverr_q & psel & penable;

	// Writable configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q      <= `DIMR_CTRL_RESET;
			start_sel_q <= `DIMR_START_RESET; // RULE11
			for (int k = 0; k < 10; k++) begin
				timer_q[k] <= 32'h0000_0000;
			end
		end else if (wr_access) begin
			if (paddr == `DIMR_OFF_CTRL) begin
				ctrl_q <= pwdata & 32'h00FF_FF7F;
			end
			if (paddr == `DIMR_OFF_START_SEL && pwdata[4:0] < 5'd24) begin
				start_sel_q <= pwdata[4:0]; // RULE10
			end
			if (is_timer) begin
				timer_q[tidx] <= pwdata;
			end
		end
	end

	// Read data and error flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			pslverr_q <= !mapped;
			if (is_timer) begin
				prdata_q <= timer_q[tidx];
			end else begin
				case (paddr)
					`DIMR_OFF_CTRL:      prdata_q <= ctrl_q;
					`DIMR_OFF_START_SEL: prdata_q <= {27'h000_0000, start_sel_q};
					`DIMR_OFF_LOCAL:     prdata_q <= {23'h00_0000, local_paired_enable, local_board}; // RULE7
					`DIMR_OFF_SERIAL:    prdata_q <= {22'h00_0000, serial_q};
					`DIMR_OFF_FIELDBUS:  prdata_q <= {22'h00_0000, fieldbus_q};
					`DIMR_OFF_COMBINED:  prdata_q <= {22'h00_0000, bif.combined};
					`DIMR_OFF_DELAYED:   prdata_q <= {22'h00_0000, bif.delayed};
					`DIMR_OFF_RUN:       prdata_q <= {28'h000_0000, ref_force_zero, decel_active, run_reverse, run};
					default:             prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // dimr_top

// ### core/dimr_defines.svh
// Register map, field positions, reset values and timing counts of the input merge block
//Behaviour
//RULE1: Each of eight combined inputs is the OR across all active boards.
//RULE2: Combined enable ANDs local paired enable with active remote enables, unless bypassed.
//RULE3: Local paired enable is active only when channels A and B both are.
//RULE4: Software enable ANDs its assigned input across all active boards.
//RULE5: Combined board carries ten signals: eight inputs, enable, software enable.
//RULE6: Every combined signal passes its own delay timer; commands use the delayed board.
//RULE7: Status shows local, serial, fieldbus, combined and delayed boards.
//RULE8: Enable fixed to input two, reset to input three, reset can be disabled.
//RULE9: Inputs six, seven, eight also feed encoder and frequency channels.
//RULE10: Start source selectable from inputs, auxiliary inputs, virtual outputs, timed flags.
//RULE11: Start defaults to input one; its terminal may serve other functions.
//RULE12: Start with enable asserts run; setpoint ramps to the reference.
//RULE13: Start inactive drops run, forces reference zero, decelerates.
//RULE14: In scalar frequency control run needs a nonzero main reference.
//RULE15: With reverse assigned, start and reverse together drop run.
//RULE16: With reverse assigned, start alone is forward, reverse alone is reverse.
//RULE17: Jog may change run only when no other function asserts run.
//RULE18: With stop assigned, run changes only on pulse key actions.
//RULE19: Keypad as only source: start key asserts run, stop key drops it.
//RULE20: Free wheel stop mode skips deceleration and goes straight to standby.
//RULE21: Enable delay applies to assertion only; deassertion is immediate.
//RULE22: Terminal inputs are registered first; combined outputs reset inactive.
`ifndef DIMR_DEFINES_SVH
`define DIMR_DEFINES_SVH

// Byte offsets
`define DIMR_OFF_CTRL      12'h000
`define DIMR_OFF_START_SEL 12'h004
`define DIMR_OFF_LOCAL     12'h010
`define DIMR_OFF_SERIAL    12'h014
`define DIMR_OFF_FIELDBUS  12'h018
`define DIMR_OFF_COMBINED  12'h01C
`define DIMR_OFF_DELAYED   12'h020
`define DIMR_OFF_RUN       12'h024
`define DIMR_OFF_TIMER0    12'h040
`define DIMR_OFF_TIMER9    12'h064

// Control register fields
`define DIMR_CTRL_SER_ACT   0
`define DIMR_CTRL_FB_ACT    1
`define DIMR_CTRL_BYPASS    2
`define DIMR_CTRL_RST_DIS   3
`define DIMR_CTRL_KEYPAD    4
`define DIMR_CTRL_SCALAR    5
`define DIMR_CTRL_FREEWHEEL 6
`define DIMR_CTRL_REV_LSB   8
`define DIMR_CTRL_JOG_LSB   12
`define DIMR_CTRL_STOP_LSB  16
`define DIMR_CTRL_SWEN_LSB  20
`define DIMR_CTRL_RESET     32'h0000_0000
`define DIMR_START_RESET    5'h00

// Board bit positions
`define DIMR_BIT_ENABLE 8
`define DIMR_BIT_SWEN   9

// Timing: 1 ms timer tick at 10 MHz
`define DIMR_CLK_HZ     10000000
`define DIMR_TICK_US    1000
`define DIMR_TICK_CYC   ((`DIMR_CLK_HZ / 1000000) * `DIMR_TICK_US)

`endif

// ### core/dimr_pkg.sv
// Types shared by the input merge block
package dimr_pkg;
	typedef enum logic [1:0] {
		DIMR_STANDBY,
		DIMR_RUNNING,
		DIMR_DECEL
	} dimr_run_e;

	typedef logic [9:0] dimr_board_t;
endpackage

// ### core/dimr_board_if.sv
// Carrier between the merge logic and the board delay timers
interface dimr_board_if;
	import dimr_pkg::*;
	dimr_board_t combined;
	dimr_board_t delayed;
	logic        tick;
	logic [31:0] timer_cfg [10];

	modport merge (output combined, output tick, output timer_cfg, input delayed);
	modport delay (input combined, input tick, input timer_cfg, output delayed);
endinterface

// ### core/dimr_pin_sync.sv
// Two flip-flop synchroniser for field contact pins
module dimr_pin_sync #(
	parameter int W = 9
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync
);
	logic [W-1:0] meta_q;

	// First stage is read only by the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q   <= '0;
			pin_sync <= '0;
		end else begin
			meta_q   <= pin_in;
			pin_sync <= meta_q;
		end
	end
endmodule // dimr_pin_sync

// ### core/dimr_board_delay.sv
// On and off delay timers, one per combined board signal; the enable timer delays assertion only
`include "dimr_defines.svh"
module dimr_board_delay
	import dimr_pkg::*;
#(
	parameter int CW = 16
) (
	input  wire logic   pclk,
	input  wire logic   presetn,
	dimr_board_if.delay bd
);
	genvar i;
	generate
		for (i = 0; i < 10; i++) begin : g_tmr
			logic [CW-1:0] cnt_q;
			logic          out_q;
			logic [CW-1:0] on_cnt;
			logic [CW-1:0] off_cnt;
			assign on_cnt  = bd.timer_cfg[i][CW-1:0];
			assign off_cnt = bd.timer_cfg[i][16+CW-1:16];
			assign bd.delayed[i] = out_q;

			// Counts ticks while the input differs from the output
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_q <= '0;
					out_q <= 1'b0; // RULE22
				end else if (bd.combined[i] == out_q) begin
					cnt_q <= '0;
				end else if (i == `DIMR_BIT_ENABLE && !bd.combined[i]) begin
					out_q <= 1'b0; // RULE21
					cnt_q <= '0;
				end else if (cnt_q >= (bd.combined[i] ? on_cnt : off_cnt)) begin
					out_q <= bd.combined[i]; // RULE6
					cnt_q <= '0;
				end else if (bd.tick) begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	endgenerate
endmodule // dimr_board_delay

// ### tb/dimr_top_props.sv
// Port level checker of the input merge and run logic
module dimr_top_props #(
	parameter int TICK_CYC = 10000
) (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic [7:0] local_pins,
	input wire logic       enable_b_pin,
	input wire logic       run,
	input wire logic       decel_active,
	input wire logic       ref_force_zero,
	input wire logic       drive_enable,
	input wire logic       encoder_channel_a,
	input wire logic       encoder_channel_b,
	input wire logic       frequency_input_a,
	input wire logic       frequency_input_b
);
	timeunit 1ns;
	timeprecision 1ns;
	// One domain, so clock and reset are given once
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ref_zero_idle: assert property (ref_force_zero == !run) else $error("reference not forced");
	a_run_needs_en: assert property ($rose(run) |-> $past(drive_enable)) else $error("run without enable");
	a_en_low_halts: assert property (!drive_enable |=> !run) else $error("run kept without enable");
	a_en_fast_off: assert property ($fell(enable_b_pin) |-> ##[1:4] !drive_enable) else $error("slow disable");
	a_decel_not_run: assert property (decel_active |-> !run && ($past(decel_active) || $past(run)))
		else $error("decel not entered from running");
	// Two sync stages; both past edges must be out of reset
	a_enc_a_pin: assert property ($past(presetn) && $past(presetn, 2) |->
		encoder_channel_a == $past(local_pins[5], 2) && frequency_input_a == encoder_channel_a)
		else $error("channel a mismatch");
	a_enc_b_pin: assert property ($past(presetn) && $past(presetn, 2) |->
		encoder_channel_b == $past(local_pins[6], 2) && frequency_input_b == $past(local_pins[7], 2))
		else $error("channel b mismatch");
	a_err_access: assert property (pslverr |-> psel && penable) else $error("error outside access");
	a_zero_wait: assert property (psel && penable |-> pready) else $error("wait state seen");
endmodule // dimr_top_props

bind dimr_top dimr_top_props #(.TICK_CYC(TICK_CYC)) i_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
	.local_pins, .enable_b_pin, .run, .decel_active, .ref_force_zero, .drive_enable, .encoder_channel_a,
	.encoder_channel_b, .frequency_input_a, .frequency_input_b);

// ### tb/dimr_field_model.sv
// Field contacts and link masters on the far side of the drive
module dimr_field_model (
	input  wire logic        pclk,
	input  wire logic [28:0] want,
	output logic      [7:0]  local_pins,
	output logic             enable_b_pin,
	output logic      [9:0]  serial_board,
	output logic      [9:0]  fieldbus_board
);
	timeunit 1ns;
	timeprecision 1ns;
	// Contacts move just after an edge, settled a full cycle before the design samples them
	always_ff @(posedge pclk) begin
		{enable_b_pin, local_pins, serial_board, fieldbus_board} <= want;
	end
endmodule // dimr_field_model

// ### tb/dimr_top_tb.sv
// Self-checking bench of the input merge and run logic
module dimr_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, ctl, r;
	logic [7:0]  lp = '0, aux = '0, local_pins;
	logic [3:0]  vao = '0, tfl = '0;
	logic        enb = 0, kst = 0, ksp = 0, mrn = 0, raz = 0, enable_b_pin;
	logic [9:0]  sb = '0, fb = '0, x, serial_board, fieldbus_board;
	logic        run, run_reverse, decel_active, ref_force_zero, drive_enable, alarm_reset;
	logic [4:0]  sels [8] = '{5'h00, 5'h07, 5'h08, 5'h0F, 5'h10, 5'h13, 5'h14, 5'h17};
	int          num_errors = 0, checks = 0, cyc = 0, seed = 32'h1bcd;

	dimr_field_model i_far (.pclk, .want({enb, lp, sb, fb}), .local_pins, .enable_b_pin, .serial_board,
		.fieldbus_board);
	dimr_top #(.TICK_CYC(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .local_pins, .enable_b_pin, .serial_board, .fieldbus_board, .auxiliary_inputs(aux),
		.virtual_aux_outputs(vao), .timed_flags(tfl), .keypad_start_key(kst), .keypad_stop_key(ksp),
		.main_ref_nonzero(mrn), .ramp_at_zero(raz), .run, .run_reverse, .decel_active, .ref_force_zero,
		.drive_enable, .alarm_reset, .encoder_channel_a(), .encoder_channel_b(), .frequency_input_a(),
		.frequency_input_b());

	initial begin
		forever #50 pclk = ~pclk;
	end

	// Hang guard, far above the roughly 820 cycles needed
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			stop_test;
		end
	end

	task automatic stop_test;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic st(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
		apb(1'b0, a, '0);
		chk({e, r}, {ee, exp});
	endtask

	task automatic rn(input logic [1:0] ex);
		st(10);
		chk({decel_active, run}, ex);
	endtask

	task automatic src(input logic [4:0] s, input logic v);
		if (s < 5'h08) lp[s[2:0]] <= v;
		else if (s < 5'h10) aux[s[2:0]] <= v;
		else if (s < 5'h14) vao[s[1:0]] <= v;
		else tfl[s[1:0]] <= v;
	endtask

	// Combined board expected from the control word and every board
	function automatic logic [9:0] comb_x(input logic [31:0] c, input logic [7:0] p, input logic b,
		input logic [9:0] s, input logic [9:0] f);
		logic [9:0] y;
		logic [3:0] n;
		n = c[23:20];
		y[7:0] = p | (c[0] ? s[7:0] : 8'h00) | (c[1] ? f[7:0] : 8'h00);
		y[8] = p[1] & b & (c[2] | ((!c[0] | s[8]) & (!c[1] | f[8])));
		y[9] = (n == 4'h0) ? 1'b1 : (n > 4'h8) ? 1'b0 : p[n-1] & (!c[0] | s[n-1]) & (!c[1] | f[n-1]);
		return y;
	endfunction

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		st(3);
		chk({run, drive_enable, ref_force_zero}, 3'b001);
		rd(12'h000, '0, 1'b0);
		rd(12'h004, '0, 1'b0);
		rd(12'h024, 32'h0000_0008, 1'b0);
		rd(12'h00C, '0, 1'b1);
		apb(1'b1, 12'h01C, 32'h0000_03FF);
		rd(12'h01C, 32'h0000_0200, 1'b0);
		for (int i = 0; i < 12; i++) begin
			ctl = $random(seed) & 32'h00F0_0007;
			apb(1'b1, 12'h000, ctl);
			{enb, lp, sb, fb} <= 29'($random(seed));
			st(8);
			x = comb_x(ctl, lp, enb, sb, fb);
			rd(12'h010, {23'h0, lp[1] & enb, lp}, 1'b0);
			rd(12'h014, {22'h0, sb}, 1'b0);
			rd(12'h018, {22'h0, fb}, 1'b0);
			rd(12'h01C, {22'h0, x}, 1'b0);
			rd(12'h020, {22'h0, x}, 1'b0);
		end
		apb(1'b1, 12'h000, '0);
		{enb, lp, sb, fb} <= {1'b1, 8'h03, 20'h0_0000};
		rn(2'b01);
		lp <= 8'h02;
		rn(2'b10);
		raz <= 1'b1;
		rn(2'b00);
		raz <= 1'b0;
		apb(1'b1, 12'h000, 32'h0000_0040);
		lp <= 8'h03;
		rn(2'b01);
		lp <= 8'h02;
		rn(2'b00);
		raz <= 1'b1;
		lp <= 8'h03;
		enb <= 1'b0;
		rn(2'b00);
		enb <= 1'b1;
		apb(1'b1, 12'h000, 32'h0000_0020);
		rn(2'b00);
		mrn <= 1'b1;
		rn(2'b01);
		apb(1'b1, 12'h000, 32'h0000_0400);
		for (int i = 1; i < 4; i++) begin
			lp <= {4'h0, i[1], 2'b01, i[0]};
			st(10);
			chk({run_reverse & run, run}, {i == 2, i != 3});
		end
		apb(1'b1, 12'h000, '0);
		lp <= 8'h02;
		foreach (sels[k]) begin
			apb(1'b1, 12'h004, {27'h0, sels[k]});
			src(sels[k], 1'b1);
			rn(2'b01);
			src(sels[k], 1'b0);
			rn(2'b00);
		end
		apb(1'b1, 12'h004, 32'h0000_0018);
		rd(12'h004, 32'h0000_0017, 1'b0);
		apb(1'b1, 12'h004, '0);
		lp <= 8'h03;
		apb(1'b1, 12'h000, 32'h0000_0010);
		rn(2'b00);
		kst <= 1'b1;
		st(2);
		kst <= 1'b0;
		rn(2'b01);
		ksp <= 1'b1;
		st(2);
		ksp <= 1'b0;
		rn(2'b00);
		apb(1'b1, 12'h000, 32'h0005_0000);
		lp <= 8'h12;
		rn(2'b00);
		lp <= 8'h13;
		st(10);
		lp <= 8'h12;
		rn(2'b01);
		lp <= 8'h02;
		rn(2'b00);
		apb(1'b1, 12'h000, 32'h0000_6000);
		lp <= 8'h22;
		rn(2'b01);
		lp <= 8'h23;
		st(4);
		lp <= 8'h03;
		rn(2'b01);
		apb(1'b1, 12'h000, '0);
		lp <= 8'h06;
		st(10);
		chk({alarm_reset, drive_enable}, 2'b11);
		apb(1'b1, 12'h000, 32'h0000_0008);
		st(3);
		chk(alarm_reset, 1'b0);
		apb(1'b1, 12'h060, 32'h0003_0003);
		enb <= 1'b0;
		st(5);
		chk(drive_enable, 1'b0);
		st(5);
		enb <= 1'b1;
		st(8);
		chk(drive_enable, 1'b0);
		st(12);
		chk(drive_enable, 1'b1);
		enb <= 1'b0;
		st(4);
		stop_test;
	end
endmodule // dimr_top_tb
